/* hw/dpio_pin_cell.sv */
// one pin: drive selection, open-drain release, pull-up gating and input blocking
`timescale 1ns/1ns
module dpio_pin_cell #(
    parameter logic OPEN_DRAIN = 1'b0,
    parameter logic PULL_CAPABLE = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic latch,
    input wire logic dir,
    input wire logic pull,
    input wire logic periph_oe,
    input wire logic periph_out,
    input wire logic pin_level,
    input wire logic force_hiz,
    input wire logic keep_open,
    input wire logic digital_en,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pullup_en,
    output logic din
);

    typedef struct packed {
        logic out;
        logic oe_n;
        logic pull;
        logic din;
    } dpio_cell_t;

    dpio_cell_t s_q;
    dpio_cell_t s_d;
    logic drive;
    logic value;

    ////////////////////////////////////////////////////////////////////////////
    // next state of the pin
    always_comb begin
        s_d = s_q;
        value = periph_oe ? periph_out : latch;
        drive = periph_oe | dir;
        if (OPEN_DRAIN && value) begin
            drive = 1'b0;
        end
        if (force_hiz) begin
            drive = 1'b0;
        end
        s_d.out = value;
        s_d.oe_n = ~drive;
        // a pull-up fighting a driven low only burns current
        s_d.pull = pull & PULL_CAPABLE & ~(drive & ~value);
        if (force_hiz && !keep_open) begin
            s_d.din = 1'b0;
        end else begin
            s_d.din = pin_level & digital_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; pin released while reset holds
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{out: 1'b0, oe_n: 1'b1, pull: 1'b0, din: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.out;
    assign pin_oe_n = s_q.oe_n;
    assign pullup_en = s_q.pull;
    assign din = s_q.din;

endmodule

/* hw/dpio_pkg.sv */
// package: register map, field positions, reset values and pin layout of the dual port pin block
package dpio_pkg;

    // byte addresses of the registers on the apb bus
    localparam logic [11:0] OFS_P1_DATA = 12'h000;
    localparam logic [11:0] OFS_P1_DIR = 12'h004;
    localparam logic [11:0] OFS_P1_PULL = 12'h008;
    localparam logic [11:0] OFS_P4_DATA = 12'h00c;
    localparam logic [11:0] OFS_P4_DIR = 12'h010;
    localparam logic [11:0] OFS_P4_PULL = 12'h014;
    localparam logic [11:0] OFS_AIDR = 12'h018;
    localparam logic [11:0] OFS_CTRL = 12'h01c;
    localparam logic [11:0] OFS_STAT = 12'h020;
    // read-modify-write views of the two data registers: always return the latch
    localparam logic [11:0] OFS_P1_LATCH = 12'h040;
    localparam logic [11:0] OFS_P4_LATCH = 12'h04c;

    // implemented bits of each register
    localparam logic [7:0] P1_MASK = 8'h39;
    localparam logic [7:0] P4_MASK = 8'hf0;
    localparam logic [7:0] AIDR_MASK = 8'hc0;
    localparam logic [7:0] CTRL_MASK = 8'h01;

    // field positions
    localparam int CTRL_SPL_BIT = 0;
    localparam int STAT_HIZ_BIT = 0;
    localparam int STAT_STBY_BIT = 1;
    localparam int AIDR_LOW_BIT = 6;
    localparam int AIDR_HIGH_BIT = 7;

    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_AIDR = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;

    // pin index layout: 0..3 first port bits 0,3,4,5; 4..7 second port bits 4..7
    localparam int NPINS = 8;
    localparam logic [7:0] PIN_OPEN_DRAIN = 8'hc0;
    localparam logic [7:0] PIN_PULL_CAPABLE = 8'hfe;
    localparam logic [7:0] PIN_ANALOG = 8'h30;

endpackage

/* hw/dpio_top.sv */
// top: apb register file, pin mapping, read-back selection and interrupt forwarding of two ports
// How it works
// - direction bit 1 makes the pin an output driven from the latch bit
// - direction bit 0 makes an input; writes still update the latch, pin undriven
// - ordinary data read returns latch bits of output pins
// - ordinary data read returns the sampled pin level for input pins
// - read-modify-write reads always return the latch value
// - an enabled peripheral output drives the pin instead of the latch
// - while a peripheral drives, ordinary reads return the real pin level
// - reset clears all direction bits, every pin becomes an input
// - reset clears analog-disable bits, so analog-shared pins start digitally blocked
// - standby bit set plus stop or watch forces every pin high impedance
// - in forced standby high impedance each digital input without a kept-open interrupt input is held low
// - pins with an enabled interrupt input keep their input open in standby
// - standby bit clear leaves pins untouched in stop or watch
// - interrupt-capable pin levels always reach the interrupt circuit
// - pull-up bit 1 enables the internal pull-up
// - pull-up is forced off while the pin drives low
// - open-drain pins release to high impedance for a latch value of 1
// - first port pull-up bit 0 is read-write but does nothing
// - first port pins sit on bits 5, 4, 3 and 0; others unused
// - second port uses bits 7..4; analog-disable bits 7, 6, 1 means digital
`timescale 1ns/1ns
module dpio_top (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // standby state from the clock controller
    input wire logic standby_active,
    // interrupt input enables from the external interrupt circuit
    input wire logic ext_irq_enable_a,
    input wire logic ext_irq_enable_b,
    input wire logic ext_irq_enable_c,
    input wire logic ext_irq_enable_d,
    input wire logic ext_irq_enable_e,
    input wire logic ext_irq_control_zero,
    input wire logic irq_pin_select_control,
    // shared peripheral outputs, pin index order
    input wire logic [7:0] periph_oe,
    input wire logic [7:0] periph_out,
    // package pins, pin index order
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pullup_en,
    // gated digital input towards peripherals
    output logic [7:0] port_din,
    // levels towards the external interrupt circuit
    output logic ext_irq_line_a,
    output logic ext_irq_line_b,
    output logic ext_irq_line_c,
    output logic ext_irq_line_d,
    output logic ext_irq_line_e,
    output logic debug_timer_clock_pin
);

    typedef struct packed {
        logic [7:0] p1_latch;
        logic [7:0] p1_dir;
        logic [7:0] p1_pull;
        logic [7:0] p4_latch;
        logic [7:0] p4_dir;
        logic [7:0] p4_pull;
        logic [7:0] aidr;
        logic [7:0] ctrl;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] rdata;
        logic err;
    } dpio_state_t;

    dpio_state_t s_q;
    dpio_state_t s_d;

    logic setup_ph;
    logic write_ph;
    logic force_hiz;
    logic [7:0] pin_latch;
    logic [7:0] pin_dir;
    logic [7:0] pin_pull;
    logic [7:0] keep_open;
    logic [7:0] digital_en;
    logic [7:0] din;
    logic [7:0] pin_view;
    logic [7:0] rd_word;
    logic rd_ok;

    ////////////////////////////////////////////////////////////////////////////
    // pin mapping functions

    // gather the two port bytes into pin index order
    function automatic logic [7:0] to_pins(input logic [7:0] p1, input logic [7:0] p4);
        to_pins = {p4[7:4], p1[5:3], p1[0]};
    endfunction

    // scatter a pin vector back onto the first port byte
    function automatic logic [7:0] pins_to_p1(input logic [7:0] v);
        pins_to_p1 = {2'h0, v[3:1], 2'h0, v[0]};
    endfunction

    // scatter a pin vector back onto the second port byte
    function automatic logic [7:0] pins_to_p4(input logic [7:0] v);
        pins_to_p4 = {v[7:4], 4'h0};
    endfunction

    // masked byte write used by every register
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] nw,
                                           input logic [7:0] mask);
        wr_byte = (old & ~mask) | (nw & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus phases; no wait states, so the access phase always completes
    assign setup_ph = psel & ~penable;
    assign write_ph = psel & penable & pwrite & pstrb[0];
    assign pready = 1'b1;
    assign prdata = {24'h0, s_q.rdata};
    assign pslverr = psel & penable & s_q.err;

    ////////////////////////////////////////////////////////////////////////////
    // per-pin control vectors
    assign pin_latch = to_pins(s_q.p1_latch, s_q.p4_latch);
    assign pin_dir = to_pins(s_q.p1_dir, s_q.p4_dir);
    assign pin_pull = to_pins(s_q.p1_pull, s_q.p4_pull);

    // standby hold only when software armed it and the chip is really stopped
    assign force_hiz = s_q.ctrl[dpio_pkg::CTRL_SPL_BIT] & standby_active;

    // inputs that must stay open during standby for wake-up
    assign keep_open[0] = ext_irq_control_zero & irq_pin_select_control;
    assign keep_open[1] = ext_irq_enable_c;
    assign keep_open[2] = ext_irq_enable_b;
    assign keep_open[3] = ext_irq_enable_a;
    assign keep_open[5:4] = 2'h0;
    assign keep_open[6] = ext_irq_enable_d;
    assign keep_open[7] = ext_irq_enable_e;

    // analog-shared pins pass digital input only when their disable bit is 1
    assign digital_en = ~dpio_pkg::PIN_ANALOG |
        {2'h0, s_q.aidr[dpio_pkg::AIDR_HIGH_BIT], s_q.aidr[dpio_pkg::AIDR_LOW_BIT], 4'h0};

    ////////////////////////////////////////////////////////////////////////////
    // pin cells
    generate
        for (genvar i = 0; i < dpio_pkg::NPINS; i++) begin : g_pin
            dpio_pin_cell #(
                .OPEN_DRAIN(dpio_pkg::PIN_OPEN_DRAIN[i]),
                .PULL_CAPABLE(dpio_pkg::PIN_PULL_CAPABLE[i])
            ) u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .latch(pin_latch[i]),
                .dir(pin_dir[i]),
                .pull(pin_pull[i]),
                .periph_oe(periph_oe[i]),
                .periph_out(periph_out[i]),
                .pin_level(s_q.sync2[i]),
                .force_hiz(force_hiz),
                .keep_open(keep_open[i]),
                .digital_en(digital_en[i]),
                .pin_out(pin_out[i]),
                .pin_oe_n(pin_oe_n[i]),
                .pullup_en(pullup_en[i]),
                .din(din[i])
            );
        end
    endgenerate

    assign port_din = din;

    ////////////////////////////////////////////////////////////////////////////
    // ordinary read view: latch for plain outputs, pin level otherwise
    // the pin level seen here is already gated, so a blocked or analog input reads 0
    assign pin_view = (pin_dir & ~periph_oe & pin_latch) |
                      (~(pin_dir & ~periph_oe) & din);

    ////////////////////////////////////////////////////////////////////////////
    // read multiplexer; unused bits read as zero
    always_comb begin
        rd_word = 8'h00;
        rd_ok = 1'b1;
        case (paddr)
            dpio_pkg::OFS_P1_DATA: begin
                rd_word = pins_to_p1(pin_view);
            end
            dpio_pkg::OFS_P4_DATA: begin
                rd_word = pins_to_p4(pin_view);
            end
            dpio_pkg::OFS_P1_LATCH: begin
                rd_word = s_q.p1_latch;
            end
            dpio_pkg::OFS_P4_LATCH: begin
                rd_word = s_q.p4_latch;
            end
            dpio_pkg::OFS_P1_DIR: begin
                rd_word = s_q.p1_dir;
            end
            dpio_pkg::OFS_P4_DIR: begin
                rd_word = s_q.p4_dir;
            end
            dpio_pkg::OFS_P1_PULL: begin
                rd_word = s_q.p1_pull;
            end
            dpio_pkg::OFS_P4_PULL: begin
                rd_word = s_q.p4_pull;
            end
            dpio_pkg::OFS_AIDR: begin
                rd_word = s_q.aidr;
            end
            dpio_pkg::OFS_CTRL: begin
                rd_word = s_q.ctrl;
            end
            dpio_pkg::OFS_STAT: begin
                rd_word[dpio_pkg::STAT_HIZ_BIT] = force_hiz;
                rd_word[dpio_pkg::STAT_STBY_BIT] = standby_active;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: synchroniser, register writes, registered read data
    always_comb begin
        s_d = s_q;
        // two stages before any logic sees a pin
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        // writes land at the access edge, pin cells follow one edge later
        if (write_ph) begin
            case (paddr)
                dpio_pkg::OFS_P1_DATA, dpio_pkg::OFS_P1_LATCH: begin
                    s_d.p1_latch = wr_byte(s_q.p1_latch, pwdata[7:0], dpio_pkg::P1_MASK);
                end
                dpio_pkg::OFS_P4_DATA, dpio_pkg::OFS_P4_LATCH: begin
                    s_d.p4_latch = wr_byte(s_q.p4_latch, pwdata[7:0], dpio_pkg::P4_MASK);
                end
                dpio_pkg::OFS_P1_DIR: begin
                    s_d.p1_dir = wr_byte(s_q.p1_dir, pwdata[7:0], dpio_pkg::P1_MASK);
                end
                dpio_pkg::OFS_P4_DIR: begin
                    s_d.p4_dir = wr_byte(s_q.p4_dir, pwdata[7:0], dpio_pkg::P4_MASK);
                end
                dpio_pkg::OFS_P1_PULL: begin
                    // bit 0 is stored even though its pin has no pull-up
                    s_d.p1_pull = wr_byte(s_q.p1_pull, pwdata[7:0], dpio_pkg::P1_MASK);
                end
                dpio_pkg::OFS_P4_PULL: begin
                    s_d.p4_pull = wr_byte(s_q.p4_pull, pwdata[7:0], dpio_pkg::P4_MASK);
                end
                dpio_pkg::OFS_AIDR: begin
                    s_d.aidr = wr_byte(s_q.aidr, pwdata[7:0], dpio_pkg::AIDR_MASK);
                end
                dpio_pkg::OFS_CTRL: begin
                    s_d.ctrl = wr_byte(s_q.ctrl, pwdata[7:0], dpio_pkg::CTRL_MASK);
                end
                default: begin
                    s_d.ctrl = s_q.ctrl; // status and unmapped writes are dropped
                end
            endcase
        end
        // read data captured in the setup cycle so prdata comes from a flop
        if (setup_ph) begin
            s_d.rdata = pwrite ? 8'h00 : rd_word;
            s_d.err = ~rd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q.p1_latch <= dpio_pkg::RST_LATCH;
            s_q.p1_dir <= dpio_pkg::RST_DIR;
            s_q.p1_pull <= dpio_pkg::RST_PULL;
            s_q.p4_latch <= dpio_pkg::RST_LATCH;
            s_q.p4_dir <= dpio_pkg::RST_DIR;
            s_q.p4_pull <= dpio_pkg::RST_PULL;
            s_q.aidr <= dpio_pkg::RST_AIDR;
            s_q.ctrl <= dpio_pkg::RST_CTRL;
            s_q.sync1 <= 8'h00;
            s_q.sync2 <= 8'h00;
            s_q.rdata <= 8'h00;
            s_q.err <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt levels bypass direction, blocking and analog gating
    assign ext_irq_line_a = s_q.sync2[3];
    assign ext_irq_line_b = s_q.sync2[2];
    assign ext_irq_line_c = s_q.sync2[1];
    assign ext_irq_line_d = s_q.sync2[6];
    assign ext_irq_line_e = s_q.sync2[7];
    assign debug_timer_clock_pin = s_q.sync2[0];

endmodule

/* test/dpio_pad_model.sv */
// partner: package pads with external drivers, pull-ups and floating levels
`timescale 1ns/1ns
module dpio_pad_model (
    input wire logic pclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] float_q = 8'h00;
    ////////////////////////////////////////////////////////////////
    // an open pad wanders every cycle, so nothing can lean on a stale level
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end
    // block drive wins, then the outside driver, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pullup_en[i] | float_q[i];
        end
    end
endmodule

/* test/dpio_top_sva.sv */
// checker: port-level properties of the dual port pin block
`timescale 1ns/1ns
module dpio_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    input wire logic standby_active,
    input wire logic ext_irq_enable_a,
    input wire logic ext_irq_enable_b,
    input wire logic ext_irq_enable_c,
    input wire logic ext_irq_enable_d,
    input wire logic ext_irq_enable_e,
    input wire logic ext_irq_control_zero,
    input wire logic irq_pin_select_control,
    input wire logic [7:0] periph_oe,
    input wire logic [7:0] periph_out,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] port_din,
    input wire logic ext_irq_line_a,
    input wire logic ext_irq_line_b,
    input wire logic ext_irq_line_c,
    input wire logic ext_irq_line_d,
    input wire logic ext_irq_line_e,
    input wire logic debug_timer_clock_pin
);
    typedef struct packed {logic ctrl; logic [1:0] up;} dpio_chk_t;
    dpio_chk_t s_q;
    dpio_chk_t s_d;
    logic mapped;
    logic [7:0] keep;
    logic [5:0] lines;
    logic [5:0] pins;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // shadow of the standby pin-state bit; settle counter so $past never looks into reset
    always_comb begin
        s_d = s_q;
        if (psel && penable && pwrite && pstrb[0] && paddr == dpio_pkg::OFS_CTRL) begin
            s_d.ctrl = pwdata[0];
        end
        if (s_q.up != 2'h3) begin
            s_d.up = s_q.up + 2'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    // decoded map, standby keep-open mask and interrupt level pairs
    assign mapped = paddr inside {dpio_pkg::OFS_P1_DATA, dpio_pkg::OFS_P1_DIR, dpio_pkg::OFS_P1_PULL,
        dpio_pkg::OFS_P4_DATA, dpio_pkg::OFS_P4_DIR, dpio_pkg::OFS_P4_PULL, dpio_pkg::OFS_AIDR,
        dpio_pkg::OFS_CTRL, dpio_pkg::OFS_STAT, dpio_pkg::OFS_P1_LATCH, dpio_pkg::OFS_P4_LATCH};
    assign keep = {ext_irq_enable_e, ext_irq_enable_d, 2'h0, ext_irq_enable_a, ext_irq_enable_b,
        ext_irq_enable_c, ext_irq_control_zero & irq_pin_select_control};
    assign lines = {ext_irq_line_e, ext_irq_line_d, ext_irq_line_a, ext_irq_line_b, ext_irq_line_c,
        debug_timer_clock_pin};
    assign pins = {pin_in[7], pin_in[6], pin_in[3], pin_in[2], pin_in[1], pin_in[0]};
    ////////////////////////////////////////////////////////////////
    a_reset_inputs: assert property ($rose(presetn) |-> pin_oe_n == 8'hff && pullup_en == 8'h00)
        else $error("pins not all inputs after reset");
    a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
        else $error("slave error does not match address map");
    a_od_no_high: assert property ((~pin_oe_n & pin_out & dpio_pkg::PIN_OPEN_DRAIN) == 8'h00)
        else $error("open drain pin driven high");
    a_pull_low_off: assert property ((pullup_en & ~pin_oe_n & ~pin_out) == 8'h00)
        else $error("pull-up on while pin drives low");
    a_pull_idx_zero: assert property (!pullup_en[0])
        else $error("pull-up on pin without pull-up");
    a_periph_drive: assert property (!standby_active |=>
        (~pin_oe_n & $past(periph_oe) & 8'h3f) == ($past(periph_oe) & 8'h3f) &&
        (pin_out & $past(periph_oe) & 8'h3f) == ($past(periph_out) & $past(periph_oe) & 8'h3f))
        else $error("peripheral output not on pin");
    a_standby_hiz: assert property ((s_q.ctrl && standby_active)[*2] |-> pin_oe_n == 8'hff)
        else $error("pin driven in forced standby");
    a_standby_block: assert property ((s_q.ctrl && standby_active && $stable(keep))[*3] |->
        (port_din & ~keep) == 8'h00)
        else $error("blocked input not low in standby");
    a_irq_forward: assert property (s_q.up == 2'h3 |-> lines == $past(pins, 2))
        else $error("interrupt line does not follow pin");
    c_err: cover property (psel && penable && pslverr);
    c_hiz: cover property (s_q.ctrl && standby_active ##2 pin_oe_n == 8'hff);
    c_periph: cover property (periph_oe != 8'h00 ##1 pin_oe_n != 8'hff);
endmodule

/* test/tb_dpio_top.sv */
// testbench: apb register, pin, peripheral and standby scenarios of the dual port pin block
`timescale 1ns/1ns
module tb_dpio_top;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, standby_active = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [4:0] irq_en = 5'h00;
    logic [1:0] sel_en = 2'h0;
    logic [7:0] periph_oe = 8'h00, periph_out = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, errv;
    logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en, port_din;
    logic [5:0] lines;
    logic [11:0] ra[5] = '{dpio_pkg::OFS_P1_DIR, dpio_pkg::OFS_P4_DIR, dpio_pkg::OFS_P1_PULL,
        dpio_pkg::OFS_P4_PULL, dpio_pkg::OFS_AIDR};
    logic [7:0] rm[5] = '{8'h39, 8'hf0, 8'h39, 8'hf0, 8'hc0};
    int n_fail = 0;
    int samples_checked = 0;
    always #2 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    dpio_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .standby_active, .ext_irq_enable_a(irq_en[0]), .ext_irq_enable_b(irq_en[1]),
        .ext_irq_enable_c(irq_en[2]), .ext_irq_enable_d(irq_en[3]), .ext_irq_enable_e(irq_en[4]),
        .ext_irq_control_zero(sel_en[0]), .irq_pin_select_control(sel_en[1]), .periph_oe, .periph_out,
        .pin_in, .pin_out, .pin_oe_n, .pullup_en, .port_din, .ext_irq_line_a(lines[3]),
        .ext_irq_line_b(lines[2]), .ext_irq_line_c(lines[1]), .ext_irq_line_d(lines[4]),
        .ext_irq_line_e(lines[5]), .debug_timer_clock_pin(lines[0]));
    dpio_pad_model pads (.pclk, .pin_out, .pin_oe_n, .pullup_en, .ext_en, .ext_val, .pin_in);
    ////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is seen high; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input string name, input logic [11:0] a, input logic [7:0] exp);
        apb(1'h0, a, 8'h00);
        check(name, rdv[7:0], exp);
    endtask
    // pin path needs three edges; sample away from the edge
    task automatic wt;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #40000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        wt();
        check("oe_n", pin_oe_n, 8'hff);
        rd("p1dir", dpio_pkg::OFS_P1_DIR, 8'h00);
        rd("p4dir", dpio_pkg::OFS_P4_DIR, 8'h00);
        rd("aidr", dpio_pkg::OFS_AIDR, 8'h00);
        foreach (ra[i]) begin
            wr(ra[i], 8'hff);
            rd("mask", ra[i], rm[i]);
        end
        // all pins outputs: index pattern 8'h5b, open drain bit 6 released
        wr(dpio_pkg::OFS_P1_DATA, 8'h29);
        wr(dpio_pkg::OFS_P4_DATA, 8'h50);
        wt();
        check("oe_n", pin_oe_n, 8'h40);
        check("out", pin_out & 8'hbf, 8'h1b);
        check("pull", pullup_en, 8'h5a);
        rd("p1", dpio_pkg::OFS_P1_DATA, 8'h29);
        rd("p4", dpio_pkg::OFS_P4_DATA, 8'h50);
        // all pins inputs, driven from outside
        wr(dpio_pkg::OFS_P1_DIR, 8'h00);
        wr(dpio_pkg::OFS_P4_DIR, 8'h00);
        ext_en <= 8'hff;
        ext_val <= 8'ha6;
        wt();
        check("oe_n", pin_oe_n, 8'hff);
        check("din", port_din, 8'ha6);
        check("irq", {2'h0, lines}, 8'h26);
        rd("p1", dpio_pkg::OFS_P1_DATA, 8'h18);
        rd("p4", dpio_pkg::OFS_P4_DATA, 8'ha0);
        rd("p1rmw", dpio_pkg::OFS_P1_LATCH, 8'h29);
        rd("p4rmw", dpio_pkg::OFS_P4_LATCH, 8'h50);
        wr(dpio_pkg::OFS_P1_DATA, 8'h10);
        wt();
        check("oe_n", pin_oe_n, 8'hff);
        rd("p1rmw", dpio_pkg::OFS_P1_LATCH, 8'h10);
        wr(dpio_pkg::OFS_AIDR, 8'h00);
        wt();
        rd("p4an", dpio_pkg::OFS_P4_DATA, 8'h80);
        wr(dpio_pkg::OFS_AIDR, 8'hc0);
        // peripheral drives pins 1..3 while the latch says otherwise
        periph_oe <= 8'h0e;
        periph_out <= 8'h0a;
        ext_en <= 8'hf1;
        wt();
        check("oe_n", pin_oe_n, 8'hf1);
        check("out", pin_out & 8'h0e, 8'h0a);
        check("pull", pullup_en, 8'hfa);
        rd("p1", dpio_pkg::OFS_P1_DATA, 8'h28);
        rd("p1rmw", dpio_pkg::OFS_P1_LATCH, 8'h10);
        // standby with the pin-state bit set; pins 0 and 3 keep their input
        periph_oe <= 8'h00;
        ext_en <= 8'hff;
        ext_val <= 8'hff;
        irq_en <= 5'h01;
        sel_en <= 2'h3;
        wr(dpio_pkg::OFS_P1_DIR, 8'h39);
        wr(dpio_pkg::OFS_CTRL, 8'h01);
        standby_active <= 1'h1;
        wt();
        check("oe_n", pin_oe_n, 8'hff);
        check("din", port_din, 8'h09);
        rd("stat", dpio_pkg::OFS_STAT, 8'h03);
        standby_active <= 1'h0;
        wr(dpio_pkg::OFS_CTRL, 8'h00);
        standby_active <= 1'h1;
        wt();
        check("oe_n", pin_oe_n, 8'hf0);
        check("out", pin_out & 8'h0f, 8'h04);
        // refused accesses
        apb(1'h0, 12'h0fc, 8'h00);
        check("err", {7'h0, errv}, 8'h01);
        check("rdz", rdv[7:0], 8'h00);
        standby_active <= 1'h0;
        pstrb <= 4'h0;
        wr(dpio_pkg::OFS_P1_DIR, 8'h00);
        pstrb <= 4'hf;
        rd("strb", dpio_pkg::OFS_P1_DIR, 8'h39);
        wr(dpio_pkg::OFS_STAT, 8'hff);
        check("err", {7'h0, errv}, 8'h00);
        rd("stat", dpio_pkg::OFS_STAT, 8'h00);
        summarize();
    end
endmodule
bind dpio_top dpio_top_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr,
    .standby_active, .ext_irq_enable_a, .ext_irq_enable_b, .ext_irq_enable_c, .ext_irq_enable_d,
    .ext_irq_enable_e, .ext_irq_control_zero, .irq_pin_select_control, .periph_oe, .periph_out, .pin_in,
    .pin_out, .pin_oe_n, .pullup_en, .port_din, .ext_irq_line_a, .ext_irq_line_b, .ext_irq_line_c,
    .ext_irq_line_d, .ext_irq_line_e, .debug_timer_clock_pin);
